/* logic/gab_pkg.sv */
// constants and types for the port a/b gpio control block
package gab_pkg;
    localparam int unsigned PA_W      = 23;
    localparam int unsigned PB_W      = 11;
    localparam int unsigned EI_W      = 24;
    localparam int unsigned EI_WAKE   = 16;
    localparam int unsigned EI_FLT_N  = 8;
    localparam int unsigned EI_FLT_LO = 16;
    localparam int unsigned TRG_PER   = 8;
    localparam int unsigned FLT_CYC_DEF = 4;
    localparam int unsigned MISC_SWRST  = 16;

    // byte addresses of the register map
    localparam logic [31:0] ADR_PA_FSEL  = 32'h5600_0000;
    localparam logic [31:0] ADR_PA_DATA  = 32'h5600_0004;
    localparam logic [31:0] ADR_PB_FSEL  = 32'h5600_0010;
    localparam logic [31:0] ADR_PB_DATA  = 32'h5600_0014;
    localparam logic [31:0] ADR_PB_PUDIS = 32'h5600_0018;
    localparam logic [31:0] ADR_MISC     = 32'h5600_0080;
    localparam logic [31:0] ADR_TRIG0    = 32'h5600_0088;
    localparam logic [31:0] ADR_FLT_EN   = 32'h5600_0094;
    localparam logic [31:0] ADR_MASK     = 32'h5600_00A4;
    localparam logic [31:0] ADR_PEND     = 32'h5600_00A8;

    // values after reset, and the write mask of the misc register
    localparam logic [22:0] RST_PA_FSEL  = 23'h7F_FFFF;
    localparam logic [21:0] RST_PB_FSEL  = 22'h00_0000;
    localparam logic [10:0] RST_PB_PUDIS = 11'h000;
    localparam logic [31:0] RST_MISC     = 32'h0001_0000;
    localparam logic [31:0] MISC_WMASK   = 32'h0001_377F;
    localparam logic [23:0] RST_MASK     = 24'hFF_FFFF;

    // trigger codes, bit 2 rising, bit 1 falling
    localparam logic [2:0] TRG_LOW  = 3'h0;
    localparam logic [2:0] TRG_HIGH = 3'h1;
    localparam logic [2:0] TRG_FALL = 3'h2;
    localparam logic [2:0] TRG_RISE = 3'h4;
    localparam logic [2:0] TRG_BOTH = 3'h6;

    typedef enum logic [1:0] {PB_IN, PB_OUT, PB_ALT, PB_RSV} gab_pbfn_t;

    typedef struct packed {
        logic [14:0] spare_hi;
        logic        software_reset_bit;
        logic [1:0]  spare2;
        logic        usb_suspend1;
        logic        usb_suspend0;
        logic        spare1;
        logic [2:0]  clkout1_sel;
        logic        spare0;
        logic [2:0]  clkout0_sel;
        logic        usb_host_pad;
        logic        hiz_stop;
        logic        data_pu_dis_hi;
        logic        data_pu_dis_lo;
    } gab_misc_t;
endpackage : gab_pkg

/* logic/gab_gpio.sv */
// port a/b pin function, data, pull-up and external interrupt control
`timescale 1ns/10ps
module gab_gpio
    import gab_pkg::*;
#(
    parameter int unsigned FLT_CYC = FLT_CYC_DEF
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [31:0]       addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic [31:0]            rdata,
    output logic [PA_W-1:0]        pa_pin_out,
    input  wire logic [PA_W-1:0]   pa_alt_out,
    input  wire logic [PB_W-1:0]   pb_pin_in,
    output logic [PB_W-1:0]        pb_pin_out,
    output logic [PB_W-1:0]        pb_pin_oe,
    output logic [PB_W-1:0]        pb_pullup_en,
    input  wire logic [PB_W-1:0]   pb_alt_out,
    input  wire logic [PB_W-1:0]   pb_alt_oe,
    output logic [PB_W-1:0]        pb_alt_in,
    input  wire logic              ext_reset_n,
    input  wire logic              wdt_reset_n,
    input  wire logic [EI_W-1:0]   external_irq_line_pin,
    input  wire logic              power_off,
    output gab_misc_t              misc_out,
    output logic                   irq,
    output logic                   wake,
    output logic                   grp47_pend,
    output logic                   grp8up_pend
);

    localparam int unsigned SYN_W = PB_W + EI_W + 1;
    localparam int unsigned CW    = $clog2(FLT_CYC + 1);

    ////////////////////////////////////////////////////////////////////////
    // elaboration check
    if (FLT_CYC < 1 || FLT_CYC > 255) begin : g_bad_flt
        $error("filter length out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // registers and internal signals
    logic [PA_W-1:0]   pa_fsel_r;
    logic [PA_W-1:0]   pa_dat_r;
    logic [2*PB_W-1:0] pb_fsel_r;
    logic [PB_W-1:0]   pb_dat_r;
    logic [PB_W-1:0]   pb_pudis_r;
    gab_misc_t         misc_r;
    logic [2:0]        trig_r [EI_W];
    logic [EI_FLT_N-1:0] flt_en_r;
    logic [EI_W-1:0]   mask_r;
    logic [EI_W-1:0]   pend_r;
    logic [SYN_W-1:0]  s1_r, s2_r, s3_r, q_r;
    logic [PB_W-1:0]   pb_in_q;
    logic [EI_W-1:0]   ei_q;
    logic              ext_rst_q;
    logic [EI_W-1:0]   ei_lvl;
    logic [EI_W-1:0]   ei_prev_r;
    logic [EI_W-1:0]   ev_set;
    logic [EI_W-1:0]   w1c;
    logic [PB_W-1:0]   pb_out_nxt;
    logic [PB_W-1:0]   pb_oe_nxt;
    logic [PB_W-1:0]   pb_rdv;
    logic [PA_W-1:0]   pa_out_nxt;
    logic              rstout_nxt;
    logic [31:0]       rd_nxt;
    logic              hit;

    ////////////////////////////////////////////////////////////////////////
    // pin input synchronisers: three stages, change taken when 2nd and
    // 3rd agree so a single metastable sample never reaches the logic
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r  <= '0;
        end else begin
            s1_r <= {ext_reset_n, external_irq_line_pin, pb_pin_in};
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r  <= (s2_r & s3_r) | (q_r & (s2_r ^ s3_r));
        end
    end

    assign pb_in_q   = q_r[PB_W-1:0];
    assign ei_q      = q_r[PB_W +: EI_W];
    assign ext_rst_q = q_r[SYN_W-1];
    assign pb_alt_in = pb_in_q;

    ////////////////////////////////////////////////////////////////////////
    // pin configuration registers; no power-off input reaches them,
    // so contents survive power-off untouched
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pa_fsel_r  <= RST_PA_FSEL;
            pa_dat_r   <= '0;
            pb_fsel_r  <= RST_PB_FSEL;
            pb_dat_r   <= '0;
            pb_pudis_r <= RST_PB_PUDIS;
        end else if (wr) begin
            case (addr)
                ADR_PA_FSEL:  pa_fsel_r  <= wdata[PA_W-1:0];
                ADR_PA_DATA:  pa_dat_r   <= wdata[PA_W-1:0];
                ADR_PB_FSEL:  pb_fsel_r  <= wdata[2*PB_W-1:0];
                ADR_PB_DATA:  pb_dat_r   <= wdata[PB_W-1:0];
                ADR_PB_PUDIS: pb_pudis_r <= wdata[PB_W-1:0];
                default: ;
            endcase
        end
    end

    // misc control, reserved bits forced to zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            misc_r <= gab_misc_t'(RST_MISC);
        end else if (wr && addr == ADR_MISC) begin
            misc_r <= gab_misc_t'(wdata & MISC_WMASK);
        end
    end

    assign misc_out = misc_r;

    // interrupt configuration: trigger codes, filter enables, mask
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < EI_W; i++) begin
                trig_r[i] <= TRG_LOW;
            end
            flt_en_r <= '0;
            mask_r   <= RST_MASK;
        end else if (wr) begin
            for (int k = 0; k < EI_W / TRG_PER; k++) begin
                if (addr == ADR_TRIG0 + 32'(4 * k)) begin
                    for (int j = 0; j < TRG_PER; j++) begin
                        trig_r[TRG_PER*k+j] <= wdata[4*j +: 3];
                    end
                end
            end
            if (addr == ADR_FLT_EN) begin
                flt_en_r <= wdata[EI_FLT_N-1:0];
            end
            if (addr == ADR_MASK) begin
                mask_r <= wdata[EI_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port a: output data or alternate function; pin 21 alternate is
    // the combined reset output, low if any source is low
    assign rstout_nxt = ext_rst_q & wdt_reset_n & misc_r.software_reset_bit;

    always_comb begin
        for (int i = 0; i < PA_W; i++) begin
            pa_out_nxt[i] = pa_fsel_r[i] ? pa_alt_out[i] : pa_dat_r[i];
        end
        if (pa_fsel_r[21]) begin
            pa_out_nxt[21] = rstout_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port b per-pin function decode
    for (genvar i = 0; i < PB_W; i++) begin : g_pb
        gab_pbfn_t fn;
        assign fn = gab_pbfn_t'(pb_fsel_r[2*i +: 2]);
        // reserved code never drives, it falls to the input path
        assign pb_oe_nxt[i]  = (fn == PB_OUT) | ((fn == PB_ALT) & pb_alt_oe[i]);
        assign pb_out_nxt[i] = (fn == PB_ALT) ? pb_alt_out[i] : pb_dat_r[i];
        assign pb_rdv[i]     = (fn == PB_OUT) ? pb_dat_r[i] :
                               (fn == PB_ALT) ? 1'b0 : pb_in_q[i];
    end

    // pull-up follows only its own bit, whatever the function
    assign pb_pullup_en = ~pb_pudis_r;

    // pin drivers from flops, one cycle after the register write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pa_pin_out <= '0;
            pb_pin_out <= '0;
            pb_pin_oe  <= '0;
        end else begin
            pa_pin_out <= pa_out_nxt;
            pb_pin_out <= pb_out_nxt;
            pb_pin_oe  <= pb_oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // external interrupt lines: the top eight get a stability filter,
    // trading FLT_CYC cycles of latency for glitch immunity
    for (genvar i = 0; i < EI_W; i++) begin : g_ei
        if (i >= EI_FLT_LO) begin : g_f
            logic [CW-1:0] cnt_r;
            logic          f_r;
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    cnt_r <= '0;
                    f_r   <= 1'b0;
                end else if (ei_q[i] == f_r) begin
                    cnt_r <= '0;
                end else if (cnt_r == CW'(FLT_CYC - 1)) begin
                    f_r   <= ei_q[i];
                    cnt_r <= '0;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
            assign ei_lvl[i] = flt_en_r[i-EI_FLT_LO] ? f_r : ei_q[i];
        end else begin : g_n
            assign ei_lvl[i] = ei_q[i];
        end

        // level codes match the line, edge codes look at the last sample
        assign ev_set[i] = (trig_r[i][2:1] == 2'b00) ? (ei_lvl[i] == trig_r[i][0]) :
                           ((trig_r[i][2] & ei_lvl[i] & ~ei_prev_r[i]) |
                            (trig_r[i][1] & ~ei_lvl[i] & ei_prev_r[i]));
    end

    assign w1c = (wr && addr == ADR_PEND) ? wdata[EI_W-1:0] : '0;

    // sticky pending, a new event beats a write-one clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ei_prev_r <= '0;
            pend_r    <= '0;
        end else begin
            ei_prev_r <= ei_lvl;
            pend_r    <= (pend_r & ~w1c) | ev_set;
        end
    end

    assign irq = |(pend_r & ~mask_r);

    // wake ignores the mask; group pending honours it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wake        <= 1'b0;
            grp47_pend  <= 1'b0;
            grp8up_pend <= 1'b0;
        end else begin
            wake        <= power_off & (|ev_set[EI_WAKE-1:0]);
            grp47_pend  <= |(pend_r[7:4] & ~mask_r[7:4]);
            grp8up_pend <= |(pend_r[EI_W-1:8] & ~mask_r[EI_W-1:8]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; holes and reserved bits read zero
    always_comb begin
        rd_nxt = '0;
        hit    = 1'b1;
        case (addr)
            ADR_PA_FSEL:  rd_nxt = 32'(pa_fsel_r);
            ADR_PA_DATA:  rd_nxt = 32'(pa_dat_r & ~pa_fsel_r);
            ADR_PB_FSEL:  rd_nxt = 32'(pb_fsel_r);
            ADR_PB_DATA:  rd_nxt = 32'(pb_rdv);
            ADR_PB_PUDIS: rd_nxt = 32'(pb_pudis_r);
            ADR_MISC:     rd_nxt = misc_r;
            ADR_FLT_EN:   rd_nxt = 32'(flt_en_r);
            ADR_MASK:     rd_nxt = 32'(mask_r);
            ADR_PEND:     rd_nxt = 32'(pend_r);
            default:      hit    = 1'b0;
        endcase
        if (!hit) begin
            for (int k = 0; k < EI_W / TRG_PER; k++) begin
                if (addr == ADR_TRIG0 + 32'(4 * k)) begin
                    for (int j = 0; j < TRG_PER; j++) begin
                        rd_nxt[4*j +: 3] = trig_r[TRG_PER*k+j];
                    end
                end
            end
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= '0;
        end else begin
            rdata <= rd ? rd_nxt : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    property p_pa_out;
        @(posedge clk) disable iff (!resetn)
        !pa_fsel_r[0] |=> pa_pin_out[0] == $past(pa_dat_r[0]);
    endproperty
    a_pa_out: assert property (p_pa_out)
        else $error("port a output pin does not follow data");

    property p_rstout;
        @(posedge clk) disable iff (!resetn)
        pa_fsel_r[21] && !misc_r.software_reset_bit |=> !pa_pin_out[21];
    endproperty
    a_rstout: assert property (p_rstout)
        else $error("reset output not low on software reset");

    property p_wr_next;
        @(posedge clk) disable iff (!resetn)
        wr && addr == ADR_PA_FSEL |=> pa_fsel_r == $past(wdata[PA_W-1:0]);
    endproperty
    a_wr_next: assert property (p_wr_next)
        else $error("function select write not taken");

    property p_rsv_in;
        @(posedge clk) disable iff (!resetn)
        wr && addr == ADR_PB_FSEL && wdata[1:0] == 2'b11 |=> ##1 !pb_pin_oe[0];
    endproperty
    a_rsv_in: assert property (p_rsv_in)
        else $error("reserved code drives pin");

    property p_pullup;
        @(posedge clk) disable iff (!resetn)
        wr && addr == ADR_PB_PUDIS |=> pb_pullup_en == ~$past(wdata[PB_W-1:0]);
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pull-up enable wrong after write");

    property p_hole;
        @(posedge clk) disable iff (!resetn)
        rd && addr == ADR_PA_DATA + 32'h0000_0004 |=> rdata == 32'h0000_0000;
    endproperty
    a_hole: assert property (p_hole)
        else $error("reserved address reads nonzero");

    property p_sticky;
        @(posedge clk) disable iff (!resetn)
        ev_set[3] |=> pend_r[3] [*1];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("event lost against clear");

    property p_wake_hi;
        @(posedge clk) disable iff (!resetn)
        power_off && !(|ev_set[EI_WAKE-1:0]) |=> !wake;
    endproperty
    a_wake_hi: assert property (p_wake_hi)
        else $error("wake without low line event");

    property p_retain;
        @(posedge clk) disable iff (!resetn)
        power_off && !wr |=> $stable(pa_fsel_r) && $stable(pb_fsel_r) && $stable(pb_pudis_r);
    endproperty
    a_retain: assert property (p_retain)
        else $error("register changed in power-off");

    property p_pb_out;
        @(posedge clk) disable iff (!resetn)
        pb_fsel_r[1:0] == 2'b01 |=> pb_pin_oe[0] && pb_pin_out[0] == $past(pb_dat_r[0]);
    endproperty
    a_pb_out: assert property (p_pb_out)
        else $error("port b output pin does not follow data");

    property p_w1c;
        @(posedge clk) disable iff (!resetn)
        wr && addr == ADR_PEND && wdata[3] && !ev_set[3] |=> !pend_r[3];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("pending bit not cleared by write of one");

    property p_grp47;
        @(posedge clk) disable iff (!resetn)
        (pend_r[7:4] & ~mask_r[7:4]) == 4'h0 |=> !grp47_pend;
    endproperty
    a_grp47: assert property (p_grp47)
        else $error("masked line raised group pending");

endmodule : gab_gpio

/* test/gab_board.sv */
// board-side model of the devices and wiring on the port b pins
`timescale 1ns/10ps
module gab_board
    import gab_pkg::*;
(
    input  wire logic            clk,
    input  wire logic [PB_W-1:0] pb_pin_out,
    input  wire logic [PB_W-1:0] pb_pin_oe,
    input  wire logic [PB_W-1:0] pb_pullup_en,
    input  wire logic [PB_W-1:0] ext_val,
    input  wire logic [PB_W-1:0] ext_en,
    output logic      [PB_W-1:0] pb_pin_in
);
    logic [PB_W-1:0] float_r = '0;

    // an open, unpulled wire must not look stable, so it wanders
    always_ff @(posedge clk) begin
        float_r <= ~float_r;
    end

    // wire level: block driver first, then board, then pull-up
    always_comb begin
        for (int i = 0; i < PB_W; i++) begin
            if (pb_pin_oe[i]) begin
                pb_pin_in[i] = pb_pin_out[i];
            end else if (ext_en[i]) begin
                pb_pin_in[i] = ext_val[i];
            end else if (pb_pullup_en[i]) begin
                pb_pin_in[i] = 1'b1;
            end else begin
                pb_pin_in[i] = float_r[i];
            end
        end
    end
endmodule : gab_board

/* test/gab_gpio_tb.sv */
// self-checking bench for the port a/b gpio block
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fails++; \
    $display("Error %0t: got %h exp %h", $time, got, exp); end end
module gab_gpio_tb
    import gab_pkg::*;
;
    typedef struct packed {logic [31:0] a; logic [31:0] d; logic [31:0] e;} gab_row_t;
    logic              clk, resetn, wr, rd, ext_reset_n, wdt_reset_n, power_off;
    logic              irq, wake, grp47_pend, grp8up_pend, saw;
    logic [31:0]       addr, wdata, rdata;
    logic [PA_W-1:0]   pa_pin_out, pa_alt_out;
    logic [PB_W-1:0]   pb_pin_in, pb_pin_out, pb_pin_oe, pb_pullup_en;
    logic [PB_W-1:0]   pb_alt_out, pb_alt_oe, pb_alt_in, ext_val, ext_en;
    logic [EI_W-1:0]   external_irq_line_pin;
    gab_misc_t         misc_out;
    int                fails = 0;
    int                check_count = 0;
    logic [2:0]        codes [5] = '{TRG_LOW, TRG_HIGH, TRG_FALL, TRG_RISE, TRG_BOTH};
    logic              ex1 [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic              ex2 [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    // write, then read back: holes read zero, misc spare bits read zero
    gab_row_t          rows [9] = '{
        '{ADR_FLT_EN,    32'hFFFF_FFFF, 32'h0000_00FF},
        '{ADR_PA_FSEL,   32'h0055_AA55, 32'h0055_AA55},
        '{ADR_PB_FSEL,   32'h0015_5555, 32'h0015_5555},
        '{ADR_PB_PUDIS,  32'h0000_0555, 32'h0000_0555},
        '{ADR_MISC,      32'hFFFF_FFFF, 32'h0001_377F},
        '{32'h5600_0008, 32'hFFFF_FFFF, 32'h0000_0000},
        '{32'h5600_001C, 32'hFFFF_FFFF, 32'h0000_0000},
        '{ADR_MASK,      32'h00AB_CDEF, 32'h00AB_CDEF},
        '{ADR_TRIG0,     32'h0642_1046, 32'h0642_1046}};

    gab_gpio dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .pa_pin_out(pa_pin_out), .pa_alt_out(pa_alt_out),
        .pb_pin_in(pb_pin_in), .pb_pin_out(pb_pin_out), .pb_pin_oe(pb_pin_oe),
        .pb_pullup_en(pb_pullup_en), .pb_alt_out(pb_alt_out), .pb_alt_oe(pb_alt_oe),
        .pb_alt_in(pb_alt_in), .ext_reset_n(ext_reset_n), .wdt_reset_n(wdt_reset_n),
        .external_irq_line_pin(external_irq_line_pin), .power_off(power_off), .misc_out(misc_out), .irq(irq),
        .wake(wake), .grp47_pend(grp47_pend), .grp8up_pend(grp8up_pend));

    gab_board board (.clk(clk), .pb_pin_out(pb_pin_out), .pb_pin_oe(pb_pin_oe),
        .pb_pullup_en(pb_pullup_en), .ext_val(ext_val), .ext_en(ext_en),
        .pb_pin_in(pb_pin_in));

    ////////////////////////////////////////////////////////////////////////////////
    always #2.5 clk = ~clk;

    // one-cycle write strobe; returns on the edge that takes it
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata & m, e)
    endtask : rd_chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // wake may be a short pulse, so watch every cycle
    task automatic wait_wake();
        saw = 1'b0;
        repeat (12) begin
            tick(1);
            if (wake === 1'b1) saw = 1'b1;
        end
    endtask : wait_wake

    task automatic conclude();
        if (fails == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        conclude();
    end

    initial begin
        clk = 0; resetn = 0; addr = 0; wdata = 0; wr = 0; rd = 0; power_off = 0;
        pa_alt_out = '1; pb_alt_out = 11'h0F0; pb_alt_oe = '0; ext_val = '0; ext_en = '0;
        ext_reset_n = 1; wdt_reset_n = 1; external_irq_line_pin = '1;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        `CHK(pb_pullup_en, 11'h7FF)
        rd_chk(ADR_PA_FSEL, 32'h007F_FFFF, '1);
        rd_chk(ADR_PB_FSEL, 32'h0, '1);
        rd_chk(ADR_PB_PUDIS, 32'h0, '1);
        rd_chk(ADR_PA_DATA, 32'h0, '1);
        tick(6);
        `CHK(pa_pin_out, 23'h7F_FFFF)
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e, '1);
        end
        `CHK(misc_out, 32'h0001_377F)
        // port a as plain outputs; pins move one edge after the write
        wr_reg(ADR_PA_FSEL, 32'h0);
        wr_reg(ADR_PA_DATA, 32'h0012_3456);
        tick(1);
        `CHK(pa_pin_out, 23'h12_3456)
        // reset output: any of three low sources pulls it low
        wr_reg(ADR_PA_FSEL, 32'h0020_0000);
        tick(2);
        `CHK(pa_pin_out, 23'h32_3456)
        wdt_reset_n <= 1'b0;
        tick(2);
        `CHK(pa_pin_out[21], 1'b0)
        wdt_reset_n <= 1'b1;
        wr_reg(ADR_MISC, 32'h0);
        tick(2);
        `CHK(pa_pin_out[21], 1'b0)
        wr_reg(ADR_MISC, 32'h0001_0000);
        ext_reset_n <= 1'b0;
        tick(6);
        `CHK(pa_pin_out[21], 1'b0)
        ext_reset_n <= 1'b1;
        tick(6);
        `CHK(pa_pin_out[21], 1'b1)
        // port b outputs, then inputs, then the reserved code
        wr_reg(ADR_PB_FSEL, 32'h0015_5555);
        wr_reg(ADR_PB_DATA, 32'h0000_05A5);
        tick(1);
        `CHK(pb_pin_out, 11'h5A5)
        `CHK(pb_pin_oe, 11'h7FF)
        `CHK(pb_pullup_en, 11'h2AA)
        rd_chk(ADR_PB_DATA, 32'h0000_05A5, '1);
        ext_val <= 11'h3C3;
        ext_en <= '1;
        wr_reg(ADR_PB_FSEL, 32'h0);
        tick(8);
        `CHK(pb_pin_oe, 11'h000)
        `CHK(pb_alt_in, 11'h3C3)
        rd_chk(ADR_PB_DATA, 32'h0000_03C3, '1);
        wr_reg(ADR_PB_FSEL, 32'h003F_FFFF);
        tick(1);
        `CHK(pb_pin_oe, 11'h000)
        rd_chk(ADR_PB_DATA, 32'h0000_03C3, '1);
        // released pins: pulled bits read high, unpulled bits are not trusted
        ext_en <= '0;
        wr_reg(ADR_PB_PUDIS, 32'h0000_00F0);
        tick(8);
        `CHK(pb_pullup_en, 11'h70F)
        rd_chk(ADR_PB_DATA, 32'h0000_070F, 32'h0000_070F);
        pb_alt_oe <= '1;
        wr_reg(ADR_PB_FSEL, 32'h002A_AAAA);
        tick(2);
        `CHK(pb_pin_oe, 11'h7FF)
        `CHK(pb_pin_out, 11'h0F0)
        `CHK(pb_pullup_en, 11'h70F)
        rd_chk(ADR_PB_DATA, 32'h0, '1);
        // every trigger kind on line 0, before and after a falling edge
        wr_reg(ADR_MASK, 32'h00FF_FFFE);
        for (int i = 0; i < 5; i++) begin
            external_irq_line_pin[0] <= 1'b1;
            tick(8);
            wr_reg(ADR_TRIG0, 32'h4444_4440 | 32'(codes[i]));
            wr_reg(ADR_PEND, 32'h00FF_FFFF);
            tick(8);
            rd_chk(ADR_PEND, {31'h0, ex1[i]}, 32'h1);
            external_irq_line_pin[0] <= 1'b0;
            tick(8);
            rd_chk(ADR_PEND, {31'h0, ex2[i]}, 32'h1);
            `CHK(irq, ex2[i])
        end
        // rising edge on line 3: mask gates irq, pending stays until cleared
        wr_reg(ADR_PEND, 32'h00FF_FFFF);
        wr_reg(ADR_MASK, 32'h00FF_FFF7);
        external_irq_line_pin[3] <= 1'b0;
        tick(6);
        external_irq_line_pin[3] <= 1'b1;
        tick(8);
        `CHK(irq, 1'b1)
        wr_reg(ADR_MASK, 32'h00FF_FFFF);
        tick(1);
        `CHK(irq, 1'b0)
        rd_chk(ADR_PEND, 32'h8, 32'h8);
        wr_reg(ADR_MASK, 32'h00FF_FFF7);
        wr_reg(ADR_PEND, 32'h8);
        tick(2);
        `CHK(irq, 1'b0)
        // power-off: lines already set up as triggers before entry
        wr_reg(ADR_MASK, 32'h00FF_FFFF);
        wr_reg(ADR_PEND, 32'h00FF_FFFF);
        power_off <= 1'b1;
        external_irq_line_pin[20] <= 1'b0;
        wait_wake();
        `CHK(saw, 1'b0)
        external_irq_line_pin[20] <= 1'b1;
        external_irq_line_pin[5] <= 1'b0;
        tick(6);
        external_irq_line_pin[5] <= 1'b1;
        wait_wake();
        `CHK(saw, 1'b1)
        `CHK(grp47_pend, 1'b0)
        power_off <= 1'b0;
        rd_chk(ADR_PB_PUDIS, 32'h0000_00F0, '1);
        rd_chk(ADR_PB_FSEL, 32'h002A_AAAA, '1);
        // unmasked line 9 reaches the upper group and irq
        wr_reg(ADR_MASK, 32'h0);
        wr_reg(ADR_PEND, 32'h00FF_FFFF);
        external_irq_line_pin[9] <= 1'b0;
        tick(8);
        `CHK(grp8up_pend, 1'b1)
        `CHK(irq, 1'b1)
        // line 16: a two-cycle dip is dropped only while the filter is on
        wr_reg(ADR_FLT_EN, 32'h0000_0001);
        for (int i = 0; i < 2; i++) begin
            wr_reg(ADR_PEND, 32'h00FF_FFFF);
            external_irq_line_pin[16] <= 1'b0;
            tick(2);
            external_irq_line_pin[16] <= 1'b1;
            tick(10);
            rd_chk(ADR_PEND, (i == 1) ? 32'h0001_0000 : 32'h0, 32'h0001_0000);
            wr_reg(ADR_FLT_EN, 32'h0);
        end
        // a long dip still passes the filter
        wr_reg(ADR_FLT_EN, 32'h0000_0001);
        wr_reg(ADR_PEND, 32'h00FF_FFFF);
        external_irq_line_pin[16] <= 1'b0;
        tick(12);
        rd_chk(ADR_PEND, 32'h0001_0000, 32'h0001_0000);
        external_irq_line_pin[16] <= 1'b1;
        // second reset in mid-run
        resetn <= 1'b0;
        tick(2);
        `CHK(pb_pullup_en, 11'h7FF)
        resetn <= 1'b1;
        rd_chk(ADR_PA_FSEL, 32'h007F_FFFF, '1);
        rd_chk(ADR_MASK, 32'h00FF_FFFF, '1);
        conclude();
    end
endmodule : gab_gpio_tb
